// ===== an_np_mmd_defines.svh
// Offsets, fields and reset values of the negotiation and extended-access registers
`ifndef AN_NP_MMD_DEFINES_SVH
`define AN_NP_MMD_DEFINES_SVH
`define IDX_PARTNER_ABILITY 4'h5
`define IDX_EXPANSION       4'h6
`define IDX_LOCAL_NP        4'h7
`define IDX_PARTNER_NP      4'h8
`define IDX_EXT_CTRL        4'hd
`define IDX_EXT_DATA        4'he
`define SELECTOR_RST        5'h01
`define LOCAL_NP_RST        16'h2001
`define LOCAL_NP_WMASK      16'hb7ff
`define NP_MORE_BIT         15
`define NP_TOGGLE_BIT       11
`define CTRL_WMASK          16'hc01f
`endif

// ===== an_np_mmd_pkg.sv
// Types for the negotiation and extended-access register slice
package an_np_mmd_pkg;
   typedef enum logic [1:0] {
      op_address,
      op_data,
      op_data_inc_rw,
      op_data_inc_wr
   } ext_op_e;
endpackage : an_np_mmd_pkg

// ===== an_np_mmd_regs.sv
// APB register slice: partner ability, expansion, next pages, extended access
`timescale 1ns/1ps
`include "an_np_mmd_defines.svh"
module an_np_mmd_regs
   import an_np_mmd_pkg::*;
#(
   parameter int DEV_AW = 5,
   parameter int REG_AW = 16
) (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Negotiation engine status
   input  wire logic [10:0] partner_ability_hi,
   input  wire logic        par_det_fault,
   input  wire logic        partner_np_able,
   input  wire logic        partner_an_able,
   input  wire logic        page_rx,
   input  wire logic [15:0] partner_np_word,
   input  wire logic        tx_toggle,
   // Next page to transmit
   output logic [15:0]      local_np_word,
   // Extended device access
   output logic             ext_req,
   output logic             ext_write,
   output logic [DEV_AW-1:0] ext_dev,
   output logic [REG_AW-1:0] ext_reg,
   output logic [15:0]      ext_wdata,
   input  wire logic [15:0] ext_rdata
);

   logic [15:0] local_np;
   logic [15:0] ext_ctrl;
   logic [15:0] ext_addr;
   logic        fault_latch;
   logic        page_latch;

   wire         access    = psel & penable;
   wire         wr        = access & pwrite;
   wire         rd        = access & ~pwrite;
   wire         aligned   = paddr[1:0] == 2'b00 && paddr[11:6] == 6'h00;
   wire [3:0]   idx       = paddr[5:2];
   wire         hit_part  = aligned && idx == `IDX_PARTNER_ABILITY;
   wire         hit_exp   = aligned && idx == `IDX_EXPANSION;
   wire         hit_lnp   = aligned && idx == `IDX_LOCAL_NP;
   wire         hit_pnp   = aligned && idx == `IDX_PARTNER_NP;
   wire         hit_ctrl  = aligned && idx == `IDX_EXT_CTRL;
   wire         hit_data  = aligned && idx == `IDX_EXT_DATA;
   wire         mapped    = hit_part | hit_exp | hit_lnp | hit_pnp | hit_ctrl | hit_data;
   wire ext_op_e op       = ext_op_e'(ext_ctrl[15:14]);
   wire         data_mode = op != op_address;
   // Post increment after reads only for opcode 10, after writes for 10 and 11
   wire         inc       = hit_data && data_mode &&
                            ((wr && op != op_data) || (rd && op == op_data_inc_rw));
   wire         exp_read  = rd && hit_exp;

   // Latched flags: set has priority over the read that clears them
   wire next_fault = par_det_fault | (fault_latch & ~exp_read);
   wire next_page  = page_rx | (page_latch & ~exp_read);

   wire [15:0] exp_word = {11'h000, fault_latch | par_det_fault, partner_np_able, 1'b1,
                           page_latch | page_rx, partner_an_able};
   wire [15:0] lnp_word = {local_np[15:12], tx_toggle, local_np[10:0]};
   wire [15:0] pnp_word = partner_np_word;

   wire [15:0] next_rdata =
      hit_part ? {partner_ability_hi, `SELECTOR_RST} :
      hit_exp  ? exp_word :
      hit_lnp  ? lnp_word :
      hit_pnp  ? pnp_word :
      hit_ctrl ? ext_ctrl :
      hit_data ? (data_mode ? ext_rdata : ext_addr) : 16'h0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_np <= `LOCAL_NP_RST;
      end else if (wr && hit_lnp) begin
         local_np <= pwdata[15:0] & `LOCAL_NP_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_ctrl <= 16'h0000;
      end else if (wr && hit_ctrl) begin
         ext_ctrl <= pwdata[15:0] & `CTRL_WMASK;
      end
   end

   // Address write in opcode 00, bump by one on qualifying data access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_addr <= 16'h0000;
      end else if (wr && hit_data && !data_mode) begin
         ext_addr <= pwdata[15:0];
      end else if (inc) begin
         ext_addr <= ext_addr + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_latch <= 1'b0;
         page_latch  <= 1'b0;
      end else begin
         fault_latch <= next_fault;
         page_latch  <= next_page;
      end
   end

   // Zero-wait slave; outputs registered in the setup cycle so read data lands at the start of access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         prdata  <= {16'h0000, next_rdata};
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   // Extended bus strobe: one pulse per completed data-mode access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_req       <= 1'b0;
         ext_write     <= 1'b0;
         ext_dev       <= '0;
         ext_reg       <= '0;
         ext_wdata     <= 16'h0000;
         local_np_word <= `LOCAL_NP_RST;
      end else begin
         ext_req       <= access && pready && hit_data && data_mode;
         ext_write     <= pwrite;
         ext_dev       <= ext_ctrl[DEV_AW-1:0];
         ext_reg       <= ext_addr[REG_AW-1:0];
         ext_wdata     <= pwdata[15:0];
         local_np_word <= lnp_word;
      end
   end

endmodule : an_np_mmd_regs

// ===== an_np_mmd_regs_properties.sv
// Port-level checks of the negotiation and extended-access registers
`timescale 1ns/1ps
module an_np_mmd_regs_properties (
   input wire logic pclk, presetn, pwrite, pready, ext_req, ext_write, input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata, input wire logic [15:0] local_np_word, ext_wdata);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
   a_sel_ok: assert property (s_rd(12'h014) |-> prdata[4:0] == 5'h01) else $error("sel");
   a_exp_ok: assert property (s_rd(12'h018) |-> !prdata[15:5] && prdata[2])
      else $error("expansion");
   a_ctrl_ok: assert property (s_rd(12'h034) |-> prdata[13:5] == 0) else $error("ctrl");
   a_np_rst: assert property ($rose(presetn) |-> local_np_word == 16'h2001)
      else $error("page reset");
   a_np_resv: assert property (local_np_word[14] == 1'b0) else $error("page bit 14");
   a_np_more: assert property (pready && pwrite && paddr == 12'h01c |-> ##2
      local_np_word[15] == $past(pwdata[15], 2)) else $error("page bit 15");
   a_ext_src: assert property (ext_req |-> $past(paddr) == 12'h038) else $error("src");
   a_ext_dat: assert property (ext_req && ext_write |-> ext_wdata == $past(pwdata[15:0]))
      else $error("write data");
endmodule : an_np_mmd_regs_properties

// ===== an_np_ext_device.sv
// Extended device: data tracks address so a missed increment shows
`timescale 1ns/1ps
module an_np_ext_device (input wire logic [4:0] ext_dev, input wire logic [15:0] ext_reg,
   output logic [15:0] ext_rdata);
   assign ext_rdata = ext_reg ^ {ext_dev, 11'h0a5};
endmodule : an_np_ext_device

// ===== an_np_mmd_regs_test.sv
// Self-checking bench for the negotiation and extended-access registers
`timescale 1ns/1ps
module an_np_mmd_regs_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, page_rx = 0, par_det_fault = 0;
   logic partner_np_able = 0, partner_an_able = 0, tx_toggle = 0, pready, pslverr, ext_req, ext_write;
   logic [4:0] ext_dev;
   logic [10:0] partner_ability_hi = 0;
   logic [11:0] paddr = 0;
   logic [15:0] partner_np_word = 0, local_np_word, ext_reg, ext_wdata, ext_rdata, p = 16'h0032;
   logic [31:0] pwdata = 0, prdata;
   logic [32:0] q[$];
   int fail_count = 0, cmp_count = 0, cyc = 0;
   an_np_mmd_regs i_dut (.*);
   an_np_ext_device i_ext (.ext_dev, .ext_reg, .ext_rdata);
   always #2 pclk = ~pclk;
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nx
   task automatic summarize();
      $display("%0d compared, %0d failed", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      fail_count += int'(seen !== exp);
      if (seen !== exp) $display("[FAIL] %0t got %h want %h", $time, seen, exp);
   endtask : check
   task automatic xf(input logic [7:0] a, input logic [15:0] d, input logic w = 0, s = 0);
      if (!w) q.push_back({s, 16'h0000, d});
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 4'h0, a, p, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : xf
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, q.pop_front());
      if (cyc == 1000) fail_count++;
      if (cyc == 1000) summarize();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      xf(8'h18, 16'h0004);
      p = nx(p);
      {partner_np_word, partner_ability_hi} <= {p, p[10:0]};
      {partner_np_able, partner_an_able, tx_toggle, page_rx, par_det_fault} <= {p[1:0], 3'b111};
      xf(8'h14, {p[10:0], 5'h01});
      {page_rx, par_det_fault} <= 2'b00;
      xf(8'h18, {11'h000, 1'b1, p[1], 2'b11, p[0]});
      xf(8'h18, {11'h000, 1'b0, p[1], 2'b10, p[0]});
      xf(8'h20, p);
      xf(8'h1c, 16'hffff, 1);
      xf(8'h1c, 16'hbfff);
      xf(8'h3c, 16'h0000, 0, 1);
      xf(8'h34, 16'hffff, 1);
      xf(8'h34, 16'hc01f);
      xf(8'h34, 16'h0003, 1);
      xf(8'h38, 16'h0010, 1);
      xf(8'h38, 16'h0010);
      xf(8'h34, 16'h8003, 1);
      xf(8'h38, 16'h18b5);
      xf(8'h34, 16'hc003, 1);
      xf(8'h38, 16'h18b4);
      xf(8'h38, 16'h1234, 1);
      xf(8'h38, 16'h18b7);
      xf(8'h34, 16'h4003, 1);
      xf(8'h38, 16'h18b7);
      xf(8'h38, 16'h5555, 1);
      xf(8'h38, 16'h18b7);
      summarize();
   end
endmodule : an_np_mmd_regs_test
bind an_np_mmd_regs an_np_mmd_regs_properties i_props (.pclk, .presetn, .pwrite, .pready,
   .ext_req, .ext_write, .paddr, .pwdata, .prdata, .local_np_word, .ext_wdata);
